/* File: rtl/siw_pkg.sv */
// Constants for the sub-IDLE wake and reset flag block.
// Assumes a 100 MHz reference clock and a slow subclock derived from it.
package siw_pkg;

	// ====================================================================
	// Register byte offsets
	localparam logic [7:0] OFS_POWER_SAVE_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS             = 8'h04;
	localparam logic [7:0] OFS_RESET_CAUSE_FLAGS  = 8'h08;
	localparam logic [7:0] OFS_NOISE_FILTER_CTRL  = 8'h0C;
	localparam logic [7:0] OFS_PLL_CONTROL        = 8'h10;
	localparam logic [7:0] OFS_DEBUG_MODE_CONTROL = 8'h14;
	localparam logic [7:0] OFS_IRQ_STATUS         = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLEAR          = 8'h1C;
	localparam logic [7:0] OFS_IRQ_ENABLE         = 8'h20;

	// ====================================================================
	// Field positions
	localparam int PSC_FIRST_NMI_MASK  = 0;
	localparam int PSC_SECOND_NMI_MASK = 1;
	localparam int PSC_MASKABLE_MASK   = 2;
	localparam int PSC_SUB_IDLE_REQ    = 4;
	localparam int ST_IN_SUB_IDLE      = 0;
	localparam int ST_CPU_CLOCK_RUN    = 1;
	localparam int ST_DEBUG_ACTIVE     = 2;
	localparam int ST_RAM_INVALID      = 3;
	localparam int RCF_CLOCK_MONITOR   = 0;
	localparam int RCF_WATCHDOG        = 1;
	localparam int RCF_POWER_ON        = 2;
	localparam int NFC_ENABLE          = 3;
	localparam int PLL_ENABLE_BIT      = 0;
	localparam int PLL_MAIN_OSC_STOP   = 1;
	localparam int DMC_ENABLE          = 0;
	localparam int IRQ_WAKE_DONE       = 0;
	localparam int IRQ_CLOCK_MON_RESET = 1;
	localparam int IRQ_DEBUG_ENTRY     = 2;
	localparam int IRQ_BITS            = 3;
	localparam int RCF_BITS            = 3;

	// ====================================================================
	// Reset values
	localparam logic [2:0] PSC_MASK_RESET  = 3'h7;
	localparam logic [2:0] RCF_RESET       = 3'h4;
	localparam logic [3:0] NFC_RESET       = 4'h0;
	localparam logic [2:0] IRQ_EN_RESET    = 3'h0;
	localparam logic       DMC_RESET       = 1'b1;
	// Sampling selects at or above this code are fxx/64 .. fxx/1024.
	localparam logic [2:0] NFC_SLOW_MIN    = 3'h3;

	// ====================================================================
	// Timing
	localparam int CLK_HZ            = 100_000_000;
	localparam int SUB_HZ            = 32_768;
	localparam int SUB_DIV_DEFAULT   = CLK_HZ / SUB_HZ;
	localparam int SUB_WAKE_CYCLES   = 12;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_IDLE = 2'b01,
		ST_WAKE = 2'b10
	} siw_state_type;

endpackage : siw_pkg

/* File: rtl/siw_sub_idle_wake.sv */
// Sub-IDLE standby control, wake-up timing, reset-cause flags and debug mode control.
// Assumes a classic Wishbone master on ref_clk and asynchronous pins that are synchronised here.
`timescale 1ns/1ps

// Overview of operation
// RL1 - Masked non-maskable or maskable requests are ignored and never end sub-IDLE.
// RL2 - Sub-IDLE ends twelve subclock cycles after the waking request appears.
// RL3 - Slow noise filtering on external pin three stops it waking sub-IDLE.
// RL4 - Software turns the PLL off before stopping the main oscillator.
// RL5 - Software should stop the A/D converter before entering sub-IDLE.
// RL6 - In emergency mode software avoids registers that insert wait states.
// RL7 - Reset-cause flags clear only on a written 0; a written 1 does nothing.
// RL8 - A reset event setting a flag wins over a coinciding clear.
// RL9 - Boot RAM contents are not kept across a power-on reset.
// RL10 - Debug mode control is initialised while the external reset pin is low.
// RL11 - Debug reset pin high before enable cleared enters on-chip debug mode.
// RL12 - Entering sub-IDLE with an unmasked request pending wakes at once.
// RL13 - A clock monitor reset sets the clock monitor cause flag.
// RL14 - Subclock keeps running in sub-IDLE; processor clock stays stopped until wake.
module siw_sub_idle_wake #(
	parameter int SUB_DIV = siw_pkg::SUB_DIV_DEFAULT
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// Wishbone slave
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [7:0]  wbAdr,
	input  wire logic [3:0]  wbSel,
	input  wire logic [31:0] wbDatWr,
	output logic      [31:0] wbDatRd,
	output logic             wbAck,
	// Asynchronous pins and request lines
	input  wire logic        firstNmiReq,
	input  wire logic        secondNmiReq,
	input  wire logic        maskableIrqReq,
	input  wire logic        extInterruptPinThree,
	input  wire logic        resetPin_b,
	input  wire logic        debugResetPin,
	// Same-clock reset events
	input  wire logic        clockMonitorResetEvt,
	input  wire logic        watchdogResetEvt,
	// Clock and mode outputs
	output logic             cpuClockEn,
	output logic             subClockRun,
	output logic             inSubIdle,
	output logic             pllEnable,
	output logic             mainOscStop,
	output logic             debugModeActive,
	output logic             ramContentsInvalid,
	output logic             irq
);

	// ====================================================================
	// Elaboration checks
	generate
		if (SUB_DIV < 2) begin : g_badDiv
			$error("SUB_DIV must be at least 2");
		end
	endgenerate

	// ====================================================================
	// Pin synchronisers
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] pinRaw;
	logic [NSYNC-1:0] syncMeta;
	logic [NSYNC-1:0] syncOut;

	assign pinRaw = {debugResetPin, resetPin_b, extInterruptPinThree,
	                 maskableIrqReq, secondNmiReq, firstNmiReq};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (!rst_b) begin
					syncMeta[gi] <= 1'b0;
					syncOut[gi]  <= 1'b0;
				end else begin
					syncMeta[gi] <= pinRaw[gi];
					syncOut[gi]  <= syncMeta[gi];
				end
			end
		end
	endgenerate

	logic firstNmiS, secondNmiS, maskIrqS, extThreeS, resetPinS_b, debugResetS;
	assign firstNmiS   = syncOut[0];
	assign secondNmiS  = syncOut[1];
	assign maskIrqS    = syncOut[2];
	assign extThreeS   = syncOut[3];
	assign resetPinS_b = syncOut[4];
	assign debugResetS = syncOut[5];

	// ====================================================================
	// Subclock tick divider
	logic [15:0] subDivCnt;
	logic        subTick;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			subDivCnt <= 16'h0000;
			subTick   <= 1'b0;
		end else if (subDivCnt == 16'(SUB_DIV - 1)) begin
			subDivCnt <= 16'h0000;
			subTick   <= 1'b1;
		end else begin
			subDivCnt <= subDivCnt + 16'h0001;
			subTick   <= 1'b0;
		end
	end

	// ====================================================================
	// Bus decode
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		hit = (adr == ofs);
	endfunction : hit

	logic busReq, wrStrobe, wrLow;
	assign busReq   = wbCyc && wbStb && !wbAck;
	assign wrStrobe = busReq && wbWe;
	assign wrLow    = wrStrobe && wbSel[0];

	// ====================================================================
	// Software controlled registers
	logic [2:0] maskBits;
	logic [3:0] noiseFilterControl;
	logic       debugModeEnable;
	logic       enterReq;

	assign enterReq = wrLow && hit(wbAdr, siw_pkg::OFS_POWER_SAVE_CONTROL)
	                  && wbDatWr[siw_pkg::PSC_SUB_IDLE_REQ];

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			maskBits           <= siw_pkg::PSC_MASK_RESET;
			noiseFilterControl <= siw_pkg::NFC_RESET;
		end else if (wrLow && hit(wbAdr, siw_pkg::OFS_POWER_SAVE_CONTROL)) begin
			maskBits <= wbDatWr[2:0];
		end else if (wrLow && hit(wbAdr, siw_pkg::OFS_NOISE_FILTER_CTRL)) begin
			noiseFilterControl <= wbDatWr[3:0];
		end
	end

	// The main oscillator may only stop once the PLL is off; a stop request
	// written while the PLL runs is dropped so the PLL never loses its source.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pllEnable   <= 1'b0;
			mainOscStop <= 1'b0;
		end else if (wrLow && hit(wbAdr, siw_pkg::OFS_PLL_CONTROL)) begin
			pllEnable   <= wbDatWr[siw_pkg::PLL_ENABLE_BIT];
			mainOscStop <= wbDatWr[siw_pkg::PLL_MAIN_OSC_STOP] && !pllEnable
			               && !wbDatWr[siw_pkg::PLL_ENABLE_BIT]; // RL4
		end
	end

	// ====================================================================
	// Wake request logic
	logic slowFilter, extThreeWake, wakeReq, otherWake;
	assign slowFilter   = noiseFilterControl[siw_pkg::NFC_ENABLE]
	                      && (noiseFilterControl[2:0] >= siw_pkg::NFC_SLOW_MIN);
	assign extThreeWake = extThreeS && !slowFilter; // RL3
	assign otherWake    = (firstNmiS  && !maskBits[siw_pkg::PSC_FIRST_NMI_MASK])
	                   || (secondNmiS && !maskBits[siw_pkg::PSC_SECOND_NMI_MASK])
	                   || (maskIrqS   && !maskBits[siw_pkg::PSC_MASKABLE_MASK]); // RL1
	assign wakeReq      = otherWake
	                   || (extThreeWake && !maskBits[siw_pkg::PSC_MASKABLE_MASK]); // RL1

	// ====================================================================
	// Sub-IDLE state machine
	siw_pkg::siw_state_type state, next_state;
	logic [3:0] wakeCnt;
	logic       wakeLast;

	assign wakeLast = subTick && (wakeCnt == 4'(siw_pkg::SUB_WAKE_CYCLES - 1));

	always_comb begin
		next_state = state;
		case (state)
			siw_pkg::ST_RUN: begin
				// A pending request turns the entry straight back into run.
				if (enterReq && !wakeReq) begin // RL12
					next_state = siw_pkg::ST_IDLE;
				end
			end
			siw_pkg::ST_IDLE: begin
				if (wakeReq) begin
					next_state = siw_pkg::ST_WAKE;
				end
			end
			siw_pkg::ST_WAKE: begin
				if (wakeLast) begin // RL2
					next_state = siw_pkg::ST_RUN;
				end
			end
			default: next_state = siw_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state      <= siw_pkg::ST_RUN;
			cpuClockEn <= 1'b1;
			inSubIdle  <= 1'b0;
		end else begin
			state      <= next_state;
			cpuClockEn <= (next_state == siw_pkg::ST_RUN); // RL14
			inSubIdle  <= (next_state != siw_pkg::ST_RUN);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wakeCnt <= 4'h0;
		end else if (state != siw_pkg::ST_WAKE) begin
			wakeCnt <= 4'h0;
		end else if (subTick) begin
			wakeCnt <= wakeCnt + 4'h1; // RL2
		end
	end

	// The subclock is never gated here; it times the wake-up latency.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			subClockRun <= 1'b1; // RL14
		end else begin
			subClockRun <= 1'b1;
		end
	end

	// ====================================================================
	// Reset-cause flags and boot RAM status
	logic [2:0] resetCauseFlags;
	logic [2:0] rcfSet;
	logic       rcfWrite;

	assign rcfSet   = {1'b0, watchdogResetEvt, clockMonitorResetEvt}; // RL13
	assign rcfWrite = wrLow && hit(wbAdr, siw_pkg::OFS_RESET_CAUSE_FLAGS);

	// Flags reflect a power-on reset when rst_b is the power-on source.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			resetCauseFlags <= siw_pkg::RCF_RESET;
		end else if (rcfWrite) begin
			resetCauseFlags <= (resetCauseFlags & wbDatWr[2:0]) | rcfSet; // RL7 RL8
		end else begin
			resetCauseFlags <= resetCauseFlags | rcfSet; // RL13
		end
	end

	// Boot firmware reuses part of RAM after power-on; marked invalid until
	// software acknowledges by clearing the power-on flag.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ramContentsInvalid <= 1'b1; // RL9
		end else begin
			ramContentsInvalid <= resetCauseFlags[siw_pkg::RCF_POWER_ON];
		end
	end

	// ====================================================================
	// Debug mode control
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !resetPinS_b) begin
			debugModeEnable <= siw_pkg::DMC_RESET; // RL10
			debugModeActive <= 1'b0;
		end else begin
			if (wrLow && hit(wbAdr, siw_pkg::OFS_DEBUG_MODE_CONTROL)) begin
				debugModeEnable <= wbDatWr[siw_pkg::DMC_ENABLE];
			end
			if (debugModeEnable && debugResetS) begin
				debugModeActive <= 1'b1; // RL11
			end
		end
	end

	// ====================================================================
	// Interrupt status, clear and enable
	logic [2:0] irqStatus, irqEnable, irqEvt;
	logic       wakeDoneEvt, debugEntryEvt;

	assign wakeDoneEvt   = (state == siw_pkg::ST_WAKE) && wakeLast;
	assign debugEntryEvt = debugModeEnable && debugResetS && !debugModeActive && resetPinS_b;
	assign irqEvt        = {debugEntryEvt, clockMonitorResetEvt, wakeDoneEvt};

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			irqStatus <= 3'h0;
			irqEnable <= siw_pkg::IRQ_EN_RESET;
			irq       <= 1'b0;
		end else begin
			if (wrLow && hit(wbAdr, siw_pkg::OFS_IRQ_CLEAR)) begin
				irqStatus <= (irqStatus & ~wbDatWr[2:0]) | irqEvt;
			end else begin
				irqStatus <= irqStatus | irqEvt;
			end
			if (wrLow && hit(wbAdr, siw_pkg::OFS_IRQ_ENABLE)) begin
				irqEnable <= wbDatWr[2:0];
			end
			irq <= |(irqStatus & irqEnable);
		end
	end

	// ====================================================================
	// Read data and acknowledge
	logic [31:0] rdMux;

	always_comb begin
		rdMux = 32'h0000_0000;
		case (wbAdr)
			siw_pkg::OFS_POWER_SAVE_CONTROL: rdMux[2:0] = maskBits;
			siw_pkg::OFS_STATUS: rdMux[3:0] = {ramContentsInvalid, debugModeActive,
			                                   cpuClockEn, inSubIdle};
			siw_pkg::OFS_RESET_CAUSE_FLAGS:  rdMux[2:0] = resetCauseFlags;
			siw_pkg::OFS_NOISE_FILTER_CTRL:  rdMux[3:0] = noiseFilterControl;
			siw_pkg::OFS_PLL_CONTROL:        rdMux[1:0] = {mainOscStop, pllEnable};
			siw_pkg::OFS_DEBUG_MODE_CONTROL: rdMux[0]   = debugModeEnable;
			siw_pkg::OFS_IRQ_STATUS:         rdMux[2:0] = irqStatus;
			siw_pkg::OFS_IRQ_ENABLE:         rdMux[2:0] = irqEnable;
			default:                         rdMux      = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wbAck   <= 1'b0;
			wbDatRd <= 32'h0000_0000;
		end else begin
			wbAck   <= busReq;
			wbDatRd <= (busReq && !wbWe) ? rdMux : 32'h0000_0000;
		end
	end

	// ====================================================================
	// Assertions
	property p_maskHold;
		@(posedge ref_clk) disable iff (!rst_b)
		(state == siw_pkg::ST_IDLE) && !wakeReq |=> (state == siw_pkg::ST_IDLE);
	endproperty
	a_maskHold: assert property (p_maskHold) else $error("masked request left sub-IDLE"); // RL1

	property p_wakeStart;
		@(posedge ref_clk) disable iff (!rst_b)
		(state == siw_pkg::ST_IDLE) && wakeReq |=> (state == siw_pkg::ST_WAKE) && (wakeCnt == 4'h0);
	endproperty
	a_wakeStart: assert property (p_wakeStart) else $error("wake did not start"); // RL2

	property p_wakeEnd;
		@(posedge ref_clk) disable iff (!rst_b)
		(state == siw_pkg::ST_WAKE) && subTick && (wakeCnt == 4'hB)
		|=> (state == siw_pkg::ST_RUN) && cpuClockEn;
	endproperty
	a_wakeEnd: assert property (p_wakeEnd) else $error("wake not done after 12 ticks"); // RL2

	property p_noEarly;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(state == siw_pkg::ST_RUN) |-> $past(wakeCnt) == 4'hB || $past(state) != siw_pkg::ST_WAKE;
	endproperty
	a_noEarly: assert property (p_noEarly) else $error("wake ended early"); // RL2

	property p_slowFilter;
		@(posedge ref_clk) disable iff (!rst_b)
		(state == siw_pkg::ST_IDLE) && slowFilter && !otherWake |=> (state == siw_pkg::ST_IDLE);
	endproperty
	a_slowFilter: assert property (p_slowFilter) else $error("pin three woke with slow filter"); // RL3

	property p_writeOne;
		@(posedge ref_clk) disable iff (!rst_b)
		rcfWrite && (wbDatWr[2:0] == 3'h7) && (rcfSet == 3'h0) |=> $stable(resetCauseFlags);
	endproperty
	a_writeOne: assert property (p_writeOne) else $error("written 1 changed a flag"); // RL7

	property p_setWins;
		@(posedge ref_clk) disable iff (!rst_b)
		rcfWrite && !wbDatWr[0] && clockMonitorResetEvt |=> resetCauseFlags[0] [*2];
	endproperty
	a_setWins: assert property (p_setWins) else $error("clear beat a reset event"); // RL8

	property p_ramInvalid;
		@(posedge ref_clk) !rst_b |=> ##1 ramContentsInvalid;
	endproperty
	a_ramInvalid: assert property (p_ramInvalid) else $error("RAM kept valid after power-on"); // RL9

	property p_pinInit;
		@(posedge ref_clk) disable iff (!rst_b)
		!resetPinS_b |=> debugModeEnable && !debugModeActive;
	endproperty
	a_pinInit: assert property (p_pinInit) else $error("debug control not initialised"); // RL10

	property p_debugEntry;
		@(posedge ref_clk) disable iff (!rst_b)
		resetPinS_b && debugModeEnable && debugResetS ##1 resetPinS_b |-> debugModeActive;
	endproperty
	a_debugEntry: assert property (p_debugEntry) else $error("debug mode not entered"); // RL11

	property p_pending;
		@(posedge ref_clk) disable iff (!rst_b)
		(state == siw_pkg::ST_RUN) && enterReq && wakeReq |=> (state == siw_pkg::ST_RUN);
	endproperty
	a_pending: assert property (p_pending) else $error("pending request did not wake"); // RL12

	property p_clockMon;
		@(posedge ref_clk) disable iff (!rst_b)
		clockMonitorResetEvt |=> resetCauseFlags[0] && irqStatus[1];
	endproperty
	a_clockMon: assert property (p_clockMon) else $error("clock monitor flag not set"); // RL13

	property p_cpuStop;
		@(posedge ref_clk) disable iff (!rst_b)
		(state != siw_pkg::ST_RUN) |-> !cpuClockEn && subClockRun;
	endproperty
	a_cpuStop: assert property (p_cpuStop) else $error("cpu clock ran in sub-IDLE"); // RL14

	c_enterIdle: cover property (@(posedge ref_clk) disable iff (!rst_b)
		state == siw_pkg::ST_RUN ##1 state == siw_pkg::ST_IDLE);
	c_fullWake: cover property (@(posedge ref_clk) disable iff (!rst_b) wakeDoneEvt);
	c_setClear: cover property (@(posedge ref_clk) disable iff (!rst_b)
		rcfWrite && clockMonitorResetEvt);
	c_debug: cover property (@(posedge ref_clk) disable iff (!rst_b) debugEntryEvt);

endmodule : siw_sub_idle_wake

/* File: tb/siw_sub_idle_wake_bench.sv */
// Self-checking bench for the sub-IDLE wake, reset flag and debug control block.
// Assumes the design answers every bus request with one wait cycle; the subclock is shortened.
`timescale 1ns/1ps

`define CHK(what, exp, got) begin checksDone++; if ((got) !== (exp)) begin errTotal++; \
	$display("BAD %s expected %h seen %h", what, exp, got); end end

module siw_sub_idle_wake_bench;
	// ====================================================================
	// Stimulus and observation
	localparam int SD = 4;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbDatWr = 32'h0000_0000;
	logic [31:0] wbDatRd, rd;
	logic        wbAck, cpuClockEn, subClockRun, inSubIdle, pllEnable, mainOscStop;
	logic        debugModeActive, ramContentsInvalid, irq;
	logic [2:0]  reqs = 3'h0;
	logic        pinThree = 1'b0, resetPin_b = 1'b1, debugPin = 1'b0;
	logic        clkMonEvt = 1'b0, wdtEvt = 1'b0;
	int          errTotal = 0;
	int          checksDone = 0;
	int          n;

	always #5 ref_clk = ~ref_clk;

	siw_sub_idle_wake #(.SUB_DIV(SD)) i_siw_sub_idle_wake (
		.ref_clk(ref_clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbAdr(wbAdr), .wbSel(4'h1), .wbDatWr(wbDatWr), .wbDatRd(wbDatRd), .wbAck(wbAck),
		.firstNmiReq(reqs[0]), .secondNmiReq(reqs[1]), .maskableIrqReq(reqs[2]),
		.extInterruptPinThree(pinThree), .resetPin_b(resetPin_b),
		.debugResetPin(debugPin), .clockMonitorResetEvt(clkMonEvt),
		.watchdogResetEvt(wdtEvt), .cpuClockEn(cpuClockEn), .subClockRun(subClockRun),
		.inSubIdle(inSubIdle), .pllEnable(pllEnable), .mainOscStop(mainOscStop),
		.debugModeActive(debugModeActive), .ramContentsInvalid(ramContentsInvalid),
		.irq(irq)
	);

	// ====================================================================
	// Shared tasks
	// The event pulse rides on the taking edge so a clear and a set can collide.
	// The bench never runs from the internal oscillator, so a waited access is legal.
	task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
			input logic evt);
		int k;
		k = 0;
		@(posedge ref_clk);
		wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= adr; wbDatWr <= dat;
		clkMonEvt <= evt;
		do begin
			@(posedge ref_clk);
			clkMonEvt <= 1'b0;
			k++;
		end while (wbAck !== 1'b1 && k < 50);
		rd = wbDatRd;
		wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
		if (k >= 50) `CHK("bus ack", 1'b1, 1'b0)
	endtask : wbCycle

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wbCycle(1'b1, adr, dat, 1'b0);
	endtask : wr

	task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
		wbCycle(1'b0, adr, 32'h0000_0000, 1'b0);
		`CHK("register read", exp, rd)
	endtask : rdChk

	task automatic clks(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : clks

	task automatic waitCpu;
		n = 0;
		while (cpuClockEn !== 1'b1 && n < 80) begin
			@(posedge ref_clk);
			n++;
		end
	endtask : waitCpu

	task automatic doReset;
		rst_b <= 1'b0;
		clks(8);
		rst_b <= 1'b1;
		clks(3);
	endtask : doReset

	// ====================================================================
	// Scenarios
	task automatic tResetValues;
		rdChk(siw_pkg::OFS_STATUS, 32'h0000_000A);
		rdChk(siw_pkg::OFS_RESET_CAUSE_FLAGS, 32'h0000_0004);
		rdChk(siw_pkg::OFS_POWER_SAVE_CONTROL, 32'h0000_0007);
		rdChk(siw_pkg::OFS_DEBUG_MODE_CONTROL, 32'h0000_0001);
		rdChk(siw_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
		rdChk(8'h3C, 32'h0000_0000);
		`CHK("ram invalid", 1'b1, ramContentsInvalid)
		`CHK("irq idle", 1'b0, irq)
	endtask : tResetValues

	task automatic tResetFlags;
		wr(siw_pkg::OFS_RESET_CAUSE_FLAGS, 32'h0000_00FF);
		rdChk(siw_pkg::OFS_RESET_CAUSE_FLAGS, 32'h0000_0004);
		wr(siw_pkg::OFS_RESET_CAUSE_FLAGS, 32'h0000_0000);
		rdChk(siw_pkg::OFS_RESET_CAUSE_FLAGS, 32'h0000_0000);
		`CHK("ram invalid cleared", 1'b0, ramContentsInvalid)
		clkMonEvt <= 1'b1;
		@(posedge ref_clk);
		clkMonEvt <= 1'b0;
		wdtEvt <= 1'b1;
		@(posedge ref_clk);
		wdtEvt <= 1'b0;
		rdChk(siw_pkg::OFS_RESET_CAUSE_FLAGS, 32'h0000_0003);
		wbCycle(1'b1, siw_pkg::OFS_RESET_CAUSE_FLAGS, 32'h0000_0000, 1'b1);
		rdChk(siw_pkg::OFS_RESET_CAUSE_FLAGS, 32'h0000_0001);
	endtask : tResetFlags

	task automatic tIrq;
		wr(siw_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
		wr(siw_pkg::OFS_IRQ_ENABLE, 32'h0000_0002);
		clks(3);
		`CHK("irq quiet", 1'b0, irq)
		wbCycle(1'b1, siw_pkg::OFS_IRQ_ENABLE, 32'h0000_0002, 1'b1);
		clks(3);
		`CHK("irq raised", 1'b1, irq)
		rdChk(siw_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
		wr(siw_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
		clks(3);
		`CHK("irq masked", 1'b0, irq)
		wr(siw_pkg::OFS_IRQ_ENABLE, 32'h0000_0002);
		clks(3);
		`CHK("irq unmasked", 1'b1, irq)
		wr(siw_pkg::OFS_IRQ_CLEAR, 32'h0000_0002);
		clks(3);
		`CHK("irq cleared", 1'b0, irq)
		rdChk(siw_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
	endtask : tIrq

	// Each source is held while masked, then released by clearing only its own mask.
	// The bench models no converter, so nothing is left running on entry.
	task automatic tMasks;
		for (int i = 0; i < 3; i++) begin
			wr(siw_pkg::OFS_POWER_SAVE_CONTROL, 32'h0000_0017);
			clks(2);
			`CHK("enter idle", 1'b1, inSubIdle)
			reqs[i] <= 1'b1;
			clks(70);
			`CHK("masked stays idle", 1'b1, inSubIdle)
			`CHK("cpu clock stopped", 1'b0, cpuClockEn)
			`CHK("subclock runs", 1'b1, subClockRun)
			wr(siw_pkg::OFS_POWER_SAVE_CONTROL, 32'h0000_0007 & ~(32'h0000_0001 << i));
			waitCpu();
			`CHK("wake latency", 1'b1, (n >= 11 * SD - 2) && (n <= 12 * SD + 4))
			reqs[i] <= 1'b0;
			clks(3);
		end
		rdChk(siw_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
	endtask : tMasks

	task automatic tPending;
		wr(siw_pkg::OFS_POWER_SAVE_CONTROL, 32'h0000_0000);
		reqs[2] <= 1'b1;
		clks(4);
		wr(siw_pkg::OFS_POWER_SAVE_CONTROL, 32'h0000_0010);
		clks(4);
		`CHK("pending keeps run", 1'b0, inSubIdle)
		`CHK("pending cpu clock", 1'b1, cpuClockEn)
		reqs[2] <= 1'b0;
		clks(3);
	endtask : tPending

	// A pin that cannot wake is backed up by the first non-maskable request.
	task automatic tFilter;
		logic woke;
		for (int c = 0; c < 8; c++) begin
			wr(siw_pkg::OFS_NOISE_FILTER_CTRL, 32'h0000_0008 | c);
			wr(siw_pkg::OFS_POWER_SAVE_CONTROL, 32'h0000_0010);
			clks(2);
			pinThree <= 1'b1;
			waitCpu();
			woke = cpuClockEn;
			`CHK("pin three wake", (c < 3) ? 1'b1 : 1'b0, woke)
			if (woke !== 1'b1) begin
				reqs[0] <= 1'b1;
				waitCpu();
			end
			pinThree <= 1'b0;
			reqs[0] <= 1'b0;
			clks(3);
		end
	endtask : tFilter

	task automatic tPll;
		wr(siw_pkg::OFS_PLL_CONTROL, 32'h0000_0001);
		wr(siw_pkg::OFS_PLL_CONTROL, 32'h0000_0003);
		clks(1);
		`CHK("osc kept with pll on", 1'b0, mainOscStop)
		`CHK("pll on", 1'b1, pllEnable)
		wr(siw_pkg::OFS_PLL_CONTROL, 32'h0000_0000);
		wr(siw_pkg::OFS_PLL_CONTROL, 32'h0000_0002);
		clks(1);
		`CHK("osc stop with pll off", 1'b1, mainOscStop)
		`CHK("pll off", 1'b0, pllEnable)
		wr(siw_pkg::OFS_PLL_CONTROL, 32'h0000_0000);
	endtask : tPll

	task automatic tDebug;
		wr(siw_pkg::OFS_DEBUG_MODE_CONTROL, 32'h0000_0000);
		debugPin <= 1'b1;
		clks(5);
		`CHK("debug blocked", 1'b0, debugModeActive)
		debugPin <= 1'b0;
		resetPin_b <= 1'b0;
		clks(5);
		rdChk(siw_pkg::OFS_DEBUG_MODE_CONTROL, 32'h0000_0001);
		resetPin_b <= 1'b1;
		debugPin <= 1'b1;
		clks(6);
		`CHK("debug entered", 1'b1, debugModeActive)
		rdChk(siw_pkg::OFS_STATUS, 32'h0000_0006);
		resetPin_b <= 1'b0;
		clks(5);
		`CHK("debug left on pin", 1'b0, debugModeActive)
		debugPin <= 1'b0;
		resetPin_b <= 1'b1;
		clks(3);
	endtask : tDebug

	task automatic tSecondReset;
		doReset();
		`CHK("ram invalid again", 1'b1, ramContentsInvalid)
		rdChk(siw_pkg::OFS_RESET_CAUSE_FLAGS, 32'h0000_0004);
		rdChk(siw_pkg::OFS_POWER_SAVE_CONTROL, 32'h0000_0007);
	endtask : tSecondReset

	// ====================================================================
	// Sequence, verdict and watchdog
	task automatic stopTest;
		$display("Checks made %0d, mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stopTest

	initial begin
		doReset();
		tResetValues();
		tResetFlags();
		tIrq();
		tMasks();
		tPending();
		tFilter();
		tPll();
		tDebug();
		tSecondReset();
		stopTest();
	end

	// The run needs some 1,500 cycles; the limit of 40,000 cycles leaves a wide margin.
	initial begin
		#400_000;
		errTotal++;
		stopTest();
	end
endmodule : siw_sub_idle_wake_bench
